// File: logic/pser_code_capture.sv
// A three-bit result field captured on a phase-end pulse.
// Assumes the pulse lasts one clock and the code is valid with it.
`include "pser_defines.svh"
module pser_code_capture
	import pser_pkg::*;
(
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_sys_rst,
	input  wire logic          i_hold,
	// Capture
	input  wire logic          i_capture,
	input  wire pser_code_type i_code,
	output pser_code_type      o_code
);
	pser_code_type code_r;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_hold) begin
			code_r <= '0;
		end else if (i_capture) begin
			code_r <= i_code;
		end
	end

	assign o_code = code_r;
endmodule // pser_code_capture

// File: logic/pser_defines.svh
// Offsets, field positions, reset values and masks of the port event and status bank.
// Included by every design file of the bank except the package; holds definitions only.
`ifndef PSER_DEFINES_SVH
`define PSER_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PSER_ADDR_DETECT_VIEW   8'h04
`define PSER_ADDR_DETECT_COR    8'h05
`define PSER_ADDR_FAULT_VIEW    8'h06
`define PSER_ADDR_FAULT_COR     8'h07
`define PSER_ADDR_STARTUP_VIEW  8'h08
`define PSER_ADDR_STARTUP_COR   8'h09
`define PSER_ADDR_SUPPLY_VIEW   8'h0A
`define PSER_ADDR_SUPPLY_COR    8'h0B
`define PSER_ADDR_PORT_STATUS   8'h0C

// ----------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------
`define PSER_RESET_VALUE        8'h00
`define PSER_MASK_DETECT        8'h11
`define PSER_MASK_FAULT         8'h11
`define PSER_MASK_STARTUP       8'h10
`define PSER_MASK_SUPPLY        8'h9C
`define PSER_MASK_PORT_STATUS   8'h77

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSER_BIT_DETECT_DONE    0
`define PSER_BIT_CLASS_DONE     4
`define PSER_BIT_OC_SHUTDOWN    0
`define PSER_BIT_LOAD_DISC      4
`define PSER_BIT_CLASS_OC       4
`define PSER_BIT_SUPPLY_UV      2
`define PSER_BIT_SUPPLY_OV      3
`define PSER_BIT_LOCKOUT_REL    4
`define PSER_BIT_OVERTEMP       7
`define PSER_LSB_DET_RESULT     0
`define PSER_LSB_CLASS_RESULT   4

// Interrupt summary bit positions
`define PSER_INT_SUPPLY         7
`define PSER_INT_CLASS_OC       6
`define PSER_INT_OC_SHUTDOWN    5
`define PSER_INT_CLASS_DONE     4
`define PSER_INT_DETECT_DONE    3
`define PSER_INT_LOAD_DISC      2

`endif

// File: logic/pser_event_reg.sv
// One sticky event register with a plain and a clear-on-read view.
// Assumes set pulses are already gated off while the device is held in reset.
`include "pser_defines.svh"
module pser_event_reg
	import pser_pkg::*;
#(
	parameter pser_byte_type VALID_MASK = 8'hFF
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_sys_rst,
	// Control
	input  wire logic          i_hold,
	input  wire logic          i_clear,
	input  wire pser_byte_type i_set,
	// State
	output pser_byte_type      o_value
);
	pser_byte_type value_r;
	pser_byte_type value_nxt;

	// A set in the clearing cycle survives the clear
	assign value_nxt = ((i_clear ? `PSER_RESET_VALUE : value_r) | i_set) & VALID_MASK;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_hold) begin
			value_r <= `PSER_RESET_VALUE;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign o_value = value_r;
endmodule // pser_event_reg

// File: logic/pser_event_status.sv
// Event and status register bank of a single-port power-sourcing controller.
// Assumes a serial-port decoder outside turns host reads into one-cycle read strobes.
`include "pser_defines.svh"
module pser_event_status
	import pser_pkg::*;
#(
	// Class overcurrent limit per class code, eight current codes, code 0 in the low byte
	parameter logic [63:0] CLASS_LIMITS = 64'h8080_8080_8080_8080
) (
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_sys_rst,
	// Register read port
	input  wire logic          i_reg_rd,
	input  wire pser_byte_type i_reg_addr,
	output pser_byte_type      o_reg_rdata,
	output logic               o_reg_rvalid,
	// Detection and classification
	input  wire logic          i_detect_done,
	input  wire pser_code_type i_detect_result,
	input  wire logic          i_class_done,
	input  wire pser_code_type i_class_result,
	// Port faults
	input  wire logic          i_load_removed_off,
	input  wire logic          i_startup_ok,
	input  wire logic          i_oc_event,
	input  wire logic          i_oc_shutdown,
	input  wire pser_byte_type i_port_current,
	input  wire logic          i_cutoff_manual,
	input  wire pser_byte_type i_cutoff_threshold_setting,
	// Supply and die monitors
	input  wire logic          i_supply_ov,
	input  wire logic          i_supply_uv,
	input  wire logic          i_supply_lockout,
	input  wire logic          i_thermal_shutdown,
	output logic               o_port_hold_off,
	// Interrupt summary
	input  wire logic [1:0]    i_power_event_summary,
	input  wire pser_byte_type i_int_mask,
	input  wire logic          i_global_clear_control,
	output pser_byte_type      o_int_summary,
	output logic               o_int_n
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic pser_byte_type class_limit(input pser_code_type code);
		class_limit = CLASS_LIMITS[{code, 3'b000} +: 8];
	endfunction

	function automatic pser_byte_type bit_at(input int pos, input logic v);
		bit_at = pser_byte_type'(v) << pos;
	endfunction

	// ----------------------------------------------------------------
	// Reset hold from supply lockout and thermal shutdown
	// ----------------------------------------------------------------
	pser_hold_state_type hold_state_r;
	pser_hold_state_type hold_state_nxt;
	logic                thermal_seen_r;
	logic                lockout_seen_r;
	wire logic           held      = i_supply_lockout | i_thermal_shutdown;
	wire logic           releasing = (hold_state_r == PSER_HELD) && !held;
	wire logic           run       = !held;

	always_comb begin
		hold_state_nxt = hold_state_r;
		case (hold_state_r)
			PSER_RUN: begin
				if (held) begin
					hold_state_nxt = PSER_HELD;
				end
			end
			PSER_HELD: begin
				if (!held) begin
					hold_state_nxt = PSER_RUN;
				end
			end
			default: hold_state_nxt = PSER_RUN;
		endcase
	end

	// The causes are remembered across the hold; the flags can only land after it
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			hold_state_r   <= PSER_RUN;
			thermal_seen_r <= 1'b0;
			lockout_seen_r <= 1'b0;
		end else begin
			hold_state_r   <= hold_state_nxt;
			thermal_seen_r <= held ? (thermal_seen_r | i_thermal_shutdown) : 1'b0;
			lockout_seen_r <= held ? (lockout_seen_r | i_supply_lockout) : 1'b0;
		end
	end

	assign o_port_hold_off = held || (hold_state_r == PSER_HELD);

	// ----------------------------------------------------------------
	// Overcurrent thresholds
	// ----------------------------------------------------------------
	wire pser_byte_type class_thr  = class_limit(i_class_result);
	wire pser_byte_type cutoff_thr = i_cutoff_manual ? i_cutoff_threshold_setting
	                                                 : class_thr;
	wire logic          over_class  = i_port_current > class_thr;
	wire logic          over_cutoff = i_port_current > cutoff_thr;

	// ----------------------------------------------------------------
	// Event sets
	// ----------------------------------------------------------------
	wire logic set_class_oc = run && (i_oc_event || i_oc_shutdown) && over_class;
	wire logic set_oc_off   = run && i_oc_shutdown && i_startup_ok && over_cutoff;

	wire pser_byte_type detect_set  = bit_at(`PSER_BIT_DETECT_DONE, run && i_detect_done)
	                                | bit_at(`PSER_BIT_CLASS_DONE, run && i_class_done);
	wire pser_byte_type fault_set   = bit_at(`PSER_BIT_LOAD_DISC, run && i_load_removed_off)
	                                | bit_at(`PSER_BIT_OC_SHUTDOWN, set_oc_off);
	wire pser_byte_type startup_set = bit_at(`PSER_BIT_CLASS_OC, set_class_oc);
	wire pser_byte_type supply_set  = bit_at(`PSER_BIT_SUPPLY_OV, run && i_supply_ov)
	                                | bit_at(`PSER_BIT_SUPPLY_UV, run && i_supply_uv)
	                                | bit_at(`PSER_BIT_OVERTEMP, releasing && thermal_seen_r)
	                                | bit_at(`PSER_BIT_LOCKOUT_REL, releasing && lockout_seen_r);

	// ----------------------------------------------------------------
	// Clear-on-read decode
	// ----------------------------------------------------------------
	wire logic clr_detect  = (i_reg_rd && i_reg_addr == `PSER_ADDR_DETECT_COR)
	                       || i_global_clear_control;
	wire logic clr_fault   = (i_reg_rd && i_reg_addr == `PSER_ADDR_FAULT_COR)
	                       || i_global_clear_control;
	wire logic clr_startup = (i_reg_rd && i_reg_addr == `PSER_ADDR_STARTUP_COR)
	                       || i_global_clear_control;
	wire logic clr_supply  = (i_reg_rd && i_reg_addr == `PSER_ADDR_SUPPLY_COR)
	                       || i_global_clear_control;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	pser_byte_type detect_q;
	pser_byte_type fault_q;
	pser_byte_type startup_q;
	pser_byte_type supply_q;
	pser_code_type det_code;
	pser_code_type class_code;

	pser_event_reg #(.VALID_MASK(`PSER_MASK_DETECT)) u_detect (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_hold    (held),
		.i_clear   (clr_detect),
		.i_set     (detect_set),
		.o_value   (detect_q)
	);

	pser_event_reg #(.VALID_MASK(`PSER_MASK_FAULT)) u_fault (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_hold    (held),
		.i_clear   (clr_fault),
		.i_set     (fault_set),
		.o_value   (fault_q)
	);

	pser_event_reg #(.VALID_MASK(`PSER_MASK_STARTUP)) u_startup (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_hold    (held),
		.i_clear   (clr_startup),
		.i_set     (startup_set),
		.o_value   (startup_q)
	);

	pser_event_reg #(.VALID_MASK(`PSER_MASK_SUPPLY)) u_supply (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_hold    (held),
		.i_clear   (clr_supply),
		.i_set     (supply_set),
		.o_value   (supply_q)
	);

	pser_code_capture u_det_code (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_hold    (held),
		.i_capture (run && i_detect_done),
		.i_code    (i_detect_result),
		.o_code    (det_code)
	);

	pser_code_capture u_class_code (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_hold    (held),
		.i_capture (run && i_class_done),
		.i_code    (i_class_result),
		.o_code    (class_code)
	);

	wire pser_byte_type port_status = {1'b0, class_code, 1'b0, det_code};

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire logic sel_detect  = i_reg_addr == `PSER_ADDR_DETECT_VIEW
	                      || i_reg_addr == `PSER_ADDR_DETECT_COR;
	wire logic sel_fault   = i_reg_addr == `PSER_ADDR_FAULT_VIEW
	                      || i_reg_addr == `PSER_ADDR_FAULT_COR;
	wire logic sel_startup = i_reg_addr == `PSER_ADDR_STARTUP_VIEW
	                      || i_reg_addr == `PSER_ADDR_STARTUP_COR;
	wire logic sel_supply  = i_reg_addr == `PSER_ADDR_SUPPLY_VIEW
	                      || i_reg_addr == `PSER_ADDR_SUPPLY_COR;
	wire logic sel_status  = i_reg_addr == `PSER_ADDR_PORT_STATUS;

	// Unmapped addresses read zero, matching the reserved holes around the bank
	wire pser_byte_type rd_mux = sel_detect  ? detect_q  :
	                             sel_fault   ? fault_q   :
	                             sel_startup ? startup_q :
	                             sel_supply  ? supply_q  :
	                             sel_status  ? port_status : `PSER_RESET_VALUE;

	pser_byte_type rdata_r;
	logic          rvalid_r;

	// Data is taken before the clear lands, so a clear-on-read returns the old value
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_r  <= `PSER_RESET_VALUE;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= i_reg_rd ? rd_mux : rdata_r;
			rvalid_r <= i_reg_rd;
		end
	end

	assign o_reg_rdata  = rdata_r;
	assign o_reg_rvalid = rvalid_r;

	// ----------------------------------------------------------------
	// Interrupt summary
	// ----------------------------------------------------------------
	assign o_int_summary = bit_at(`PSER_INT_SUPPLY, |supply_q)
	                     | bit_at(`PSER_INT_CLASS_OC, startup_q[`PSER_BIT_CLASS_OC])
	                     | bit_at(`PSER_INT_OC_SHUTDOWN, fault_q[`PSER_BIT_OC_SHUTDOWN])
	                     | bit_at(`PSER_INT_CLASS_DONE, detect_q[`PSER_BIT_CLASS_DONE])
	                     | bit_at(`PSER_INT_DETECT_DONE, detect_q[`PSER_BIT_DETECT_DONE])
	                     | bit_at(`PSER_INT_LOAD_DISC, fault_q[`PSER_BIT_LOAD_DISC])
	                     | {6'h00, i_power_event_summary};

	logic int_n_r;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			int_n_r <= 1'b1;
		end else begin
			int_n_r <= !(|(o_int_summary & i_int_mask));
		end
	end

	assign o_int_n = int_n_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_reset_zero: assert property (@(posedge i_clk) disable iff (1'b0)
		i_sys_rst |=> (detect_q == 8'h00 && fault_q == 8'h00 && startup_q == 8'h00))
		else $error("event registers not zero after reset");
	a_detect_done: assert property (run && i_detect_done |=> detect_q[0] && det_code == $past(i_detect_result))
		else $error("detection end not recorded");
	a_view_keeps: assert property (i_reg_rd && i_reg_addr == `PSER_ADDR_FAULT_VIEW && run
		&& !i_global_clear_control && fault_set == 8'h00 |=> fault_q == $past(fault_q))
		else $error("plain read changed fault register");
	a_cor_clears: assert property (i_reg_rd && i_reg_addr == `PSER_ADDR_DETECT_COR
		&& detect_set == 8'h00 |=> detect_q == 8'h00 && o_reg_rdata == $past(detect_q))
		else $error("clear-on-read did not return then clear");
	a_load_disc: assert property (run && i_load_removed_off |=> fault_q[4])
		else $error("load disconnect flag not set");
	a_auto_both: assert property (!i_cutoff_manual && run && i_oc_shutdown && i_startup_ok
		&& over_class |=> fault_q[0] && startup_q[4])
		else $error("automatic cutoff did not set both flags");
	a_supply_ov: assert property (run && i_supply_ov |=> supply_q[3] && o_int_summary[7])
		else $error("supply overvoltage not recorded");
	a_tsd_resume: assert property (releasing && thermal_seen_r |=> supply_q[7] && !o_port_hold_off)
		else $error("overtemperature flag missing after resume");
	a_int_low: assert property (|(o_int_summary & i_int_mask) |=> !o_int_n)
		else $error("unmasked interrupt did not drive output low");
	a_global_clr: assert property (i_global_clear_control && supply_set == 8'h00
		&& detect_set == 8'h00 |=> detect_q == 8'h00 && supply_q == 8'h00)
		else $error("global clear left events set");
	a_class_oc: assert property (run && (i_oc_event || i_oc_shutdown)
		&& i_port_current > CLASS_LIMITS[{i_class_result, 3'b000} +: 8] |=> startup_q[4])
		else $error("class overcurrent flag not set");
	a_manual_cut: assert property (run && i_cutoff_manual && i_oc_shutdown
		&& i_startup_ok && i_port_current > i_cutoff_threshold_setting |=> fault_q[0])
		else $error("manual cutoff did not set shutdown flag");
	a_manual_class: assert property (run && i_cutoff_manual && i_oc_shutdown
		&& !i_oc_event && i_port_current <= CLASS_LIMITS[{i_class_result, 3'b000} +: 8]
		&& !startup_q[4] |=> !startup_q[4])
		else $error("manual cutoff moved class overcurrent threshold");
	a_startup_keeps: assert property (i_reg_rd && i_reg_addr == `PSER_ADDR_STARTUP_VIEW
		&& run && !i_global_clear_control && startup_set == 8'h00
		|=> startup_q == $past(startup_q))
		else $error("plain read changed startup register");
	a_supply_cor: assert property (i_reg_rd && i_reg_addr == `PSER_ADDR_SUPPLY_COR
		&& supply_set == 8'h00 |=> supply_q == 8'h00 && o_reg_rdata == $past(supply_q))
		else $error("supply clear-on-read did not return then clear");
	a_status_code: assert property (run && i_class_done
		|=> port_status[6:4] == $past(i_class_result) && port_status[7] == 1'b0)
		else $error("class result not captured");
	a_held_zero: assert property (held |=> o_port_hold_off && detect_q == 8'h00
		&& fault_q == 8'h00 && startup_q == 8'h00 && supply_q == 8'h00)
		else $error("hold left port on or events set");
	a_lockout_rel: assert property (releasing && lockout_seen_r |=> supply_q[4])
		else $error("lockout release flag missing");

	c_cor_read: cover property (detect_q != 8'h00 ##1 i_reg_rd && i_reg_addr == `PSER_ADDR_DETECT_COR);
	c_thermal:  cover property (i_thermal_shutdown ##1 !held ##1 supply_q[7]);
	c_manual:   cover property (i_cutoff_manual && set_oc_off && !set_class_oc);
	c_int:      cover property ($fell(o_int_n));
	c_lockout:  cover property (i_supply_lockout ##1 !held ##1 supply_q[4]);
endmodule // pser_event_status

// File: logic/pser_pkg.sv
// Types shared by the port event and status bank.
// Assumes the defines header is compiled alongside.
package pser_pkg;
	typedef logic [7:0] pser_byte_type;
	typedef logic [2:0] pser_code_type;
	typedef enum logic {
		PSER_RUN,
		PSER_HELD
	} pser_hold_state_type;
endpackage : pser_pkg

// File: sim/pser_host_model.sv
// Host side of the register read port: one strobe per byte read.
// Assumes the bench calls read_byte from one process at a time.
module pser_host_model
	import pser_pkg::*;
(
	// Clock
	input  wire logic          i_clk,
	// Read port
	input  wire pser_byte_type i_rdata,
	input  wire logic          i_rvalid,
	output logic               o_rd,
	output pser_byte_type      o_addr,
	output logic               o_timeout
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_timeout = 1'b0;
	end

	// ----------------------------------------------------------------
	// Read cycle
	// ----------------------------------------------------------------
	// Released address is inverted so a design that samples late sees junk
	task automatic read_byte(input pser_byte_type addr, output pser_byte_type data);
		int n;
		n = 0;
		@(negedge i_clk);
		o_rd = 1'b1;
		o_addr = addr;
		@(negedge i_clk);
		o_rd = 1'b0;
		o_addr = ~addr;
		while (i_rvalid !== 1'b1 && n < 8) begin
			@(negedge i_clk);
			n++;
		end
		if (n == 8)
			o_timeout = 1'b1;
		data = i_rdata;
	endtask
endmodule // pser_host_model

// File: sim/tb_top.sv
// Self-checking bench of the port event and status bank.
// Assumes the host model sits on the read port; all other inputs come from here.
module tb_top
	import pser_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic          clk;
	logic          rst;
	logic          rd;
	logic          rvalid;
	logic          to;
	logic          ok;
	logic          manual;
	logic          ov;
	logic          uv;
	logic          lock;
	logic          therm;
	logic          hold_off;
	logic          int_n;
	logic [5:0]    pls;
	logic [1:0]    pwr;
	pser_code_type dres;
	pser_code_type cres;
	pser_byte_type addr;
	pser_byte_type rdata;
	pser_byte_type cur;
	pser_byte_type cut;
	pser_byte_type mask;
	pser_byte_type summ;
	int            bad_count;
	int            num_checks;

	// Class code 5 gets a lower limit so the class-driven threshold is visible
	pser_event_status #(.CLASS_LIMITS(64'h8080_6080_8080_8080)) dut (
		.i_clk(clk), .i_sys_rst(rst),
		.i_reg_rd(rd), .i_reg_addr(addr), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_detect_done(pls[0]), .i_detect_result(dres),
		.i_class_done(pls[1]), .i_class_result(cres),
		.i_load_removed_off(pls[2]), .i_startup_ok(ok), .i_oc_event(pls[3]),
		.i_oc_shutdown(pls[4]), .i_port_current(cur), .i_cutoff_manual(manual),
		.i_cutoff_threshold_setting(cut), .i_supply_ov(ov), .i_supply_uv(uv),
		.i_supply_lockout(lock), .i_thermal_shutdown(therm), .o_port_hold_off(hold_off),
		.i_power_event_summary(pwr), .i_int_mask(mask),
		.i_global_clear_control(pls[5]), .o_int_summary(summ), .o_int_n(int_n)
	);

	pser_host_model host (
		.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_rd(rd), .o_addr(addr), .o_timeout(to)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input pser_byte_type got, input pser_byte_type exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic rdc(input pser_byte_type a, input pser_byte_type exp);
		pser_byte_type d;
		host.read_byte(a, d);
		chk(d, exp);
		chk({7'h00, to}, 8'h00);
	endtask

	task automatic fire(input logic [5:0] p);
		@(negedge clk);
		pls = p;
		@(negedge clk);
		pls = 6'h00;
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic tally_and_finish;
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Tests need well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		rst = 1'b1;
		pls = 6'h00;
		dres = 3'b000;
		cres = 3'b000;
		cur = 8'h00;
		cut = 8'h00;
		manual = 1'b0;
		ok = 1'b0;
		ov = 1'b0;
		uv = 1'b0;
		lock = 1'b0;
		therm = 1'b0;
		mask = 8'hFF;
		pwr = 2'b00;
		bad_count = 0;
		num_checks = 0;
		idle(20);
		rst = 1'b0;
		for (int a = 0; a < 16; a++)
			rdc(a[7:0], 8'h00);
		chk({7'h00, int_n}, 8'h01);
		dres = 3'b100;
		cres = 3'b101;
		fire(6'h03);
		rdc(8'h04, 8'h11);
		rdc(8'h0C, 8'h54);
		chk(summ, 8'h18);
		chk({7'h00, int_n}, 8'h00);
		rdc(8'h05, 8'h11);
		rdc(8'h04, 8'h00);
		idle(2);
		chk({7'h00, int_n}, 8'h01);
		fire(6'h04);
		ok = 1'b1;
		cur = 8'h70;
		fire(6'h10);
		chk(summ, 8'h64);
		rdc(8'h06, 8'h11);
		rdc(8'h07, 8'h11);
		rdc(8'h06, 8'h00);
		rdc(8'h08, 8'h10);
		rdc(8'h09, 8'h10);
		rdc(8'h08, 8'h00);
		cur = 8'h60;
		fire(6'h18);
		rdc(8'h07, 8'h00);
		rdc(8'h09, 8'h00);
		ok = 1'b0;
		cur = 8'h70;
		fire(6'h10);
		rdc(8'h07, 8'h00);
		rdc(8'h09, 8'h10);
		ok = 1'b1;
		manual = 1'b1;
		cut = 8'hA0;
		cur = 8'h90;
		fire(6'h10);
		rdc(8'h07, 8'h00);
		rdc(8'h09, 8'h10);
		cur = 8'hB0;
		fire(6'h10);
		rdc(8'h07, 8'h01);
		rdc(8'h09, 8'h10);
		cut = 8'h50;
		cur = 8'h58;
		fire(6'h10);
		rdc(8'h07, 8'h01);
		rdc(8'h09, 8'h00);
		manual = 1'b0;
		cur = 8'h70;
		fire(6'h08);
		rdc(8'h08, 8'h10);
		fire(6'h05);
		fire(6'h20);
		rdc(8'h04, 8'h00);
		rdc(8'h06, 8'h00);
		rdc(8'h08, 8'h00);
		ov = 1'b1;
		idle(1);
		ov = 1'b0;
		uv = 1'b1;
		idle(1);
		uv = 1'b0;
		chk(summ, 8'h80);
		rdc(8'h0A, 8'h0C);
		rdc(8'h0B, 8'h0C);
		rdc(8'h0A, 8'h00);
		for (int k = 0; k < 2; k++) begin
			fire(6'h01);
			lock = (k == 0);
			therm = (k == 1);
			idle(3);
			chk({7'h00, hold_off}, 8'h01);
			lock = 1'b0;
			therm = 1'b0;
			idle(3);
			chk({7'h00, hold_off}, 8'h00);
			rdc(8'h04, 8'h00);
			rdc(8'h0B, (k == 1) ? 8'h80 : 8'h10);
		end
		pwr = 2'b10;
		idle(2);
		chk(summ, 8'h02);
		chk({7'h00, int_n}, 8'h00);
		mask = 8'hFD;
		idle(2);
		chk({7'h00, int_n}, 8'h01);
		pwr = 2'b00;
		fire(6'h01);
		rst = 1'b1;
		idle(2);
		rst = 1'b0;
		rdc(8'h04, 8'h00);
		tally_and_finish();
	end
endmodule // tb_top
